// ==== logic/board_ctl_pkg.sv ====
package board_ctl_pkg;

  // ==========================================================
  // Address window
  localparam int unsigned DEC_ADDR_W    = 10;
  localparam logic [2:0]  OFS_SERIAL_LO = 3'h0;
  localparam logic [2:0]  OFS_CTRL_STAT = 3'h4;
  localparam logic [2:0]  OFS_TC_CLEAR  = 3'h5;

  // ==========================================================
  // Control port write fields
  localparam int unsigned WR_DTR_A  = 0;
  localparam int unsigned WR_DTR_B  = 1;
  localparam int unsigned WR_LL_A   = 2;
  localparam int unsigned WR_RL_A   = 3;
  localparam int unsigned WR_LL_B   = 4;
  localparam int unsigned WR_RL_B   = 5;
  localparam int unsigned WR_DMA_B  = 6;
  localparam int unsigned WR_DMA_A  = 7;
  localparam logic [7:0]  CTRL_RST  = 8'h00;

  // ==========================================================
  // Status port read fields
  localparam int unsigned RD_DSR_A  = 0;
  localparam int unsigned RD_DSR_B  = 1;
  localparam int unsigned RD_TM_A   = 2;
  localparam int unsigned RD_SC_IRQ = 3;
  localparam int unsigned RD_TM_B   = 4;
  localparam int unsigned RD_TC     = 5;
  localparam int unsigned RD_DMA_B  = 6;
  localparam int unsigned RD_DMA_A  = 7;

  // ==========================================================
  // Strap encodings
  typedef enum logic [1:0] {
    DMA_SOFT   = 2'b00,
    DMA_ALWAYS = 2'b01,
    DMA_NEVER  = 2'b10
  } dma_gate_t;

  typedef enum logic [1:0] {
    IRQ_NORMAL = 2'b00,
    IRQ_SHARED = 2'b01,
    IRQ_TC     = 2'b10
  } irq_mode_t;

  // Line select: 0 none, 1..9 = lines 2/9,3,4,5,7,10,11,12,15
  localparam int unsigned IRQ_LINES = 9;

  // Modem and loopback outputs
  typedef struct packed {
    logic rl_b;
    logic ll_b;
    logic rl_a;
    logic ll_a;
    logic dtr_b;
    logic dtr_a;
  } modem_ctl_t;

  // Status inputs, raw active-high from line receivers
  typedef struct packed {
    logic tm_b;
    logic tm_a;
    logic dsr_b;
    logic dsr_a;
  } line_stat_t;

endpackage

// ==== logic/dma_gate.sv ====
`timescale 1ns/1ps
// DMA request/acknowledge driver enable for one channel
module dma_gate (
  // Clock and control
  input  wire logic                    clk_in,
  input  wire logic                    srst_in,
  input  wire logic                    ce_in,
  // Gating inputs
  input  wire board_ctl_pkg::dma_gate_t strap_in,
  input  wire logic                    soft_en_in,
  // Registered enable
  output logic                         drv_en_out
);

  logic drv_en_nxt;

  // Strap decides; illegal code treated as never for safety
  always_comb begin
    unique case (strap_in)
      board_ctl_pkg::DMA_SOFT:   drv_en_nxt = soft_en_in;
      board_ctl_pkg::DMA_ALWAYS: drv_en_nxt = 1'b1;
      board_ctl_pkg::DMA_NEVER:  drv_en_nxt = 1'b0;
      default:                   drv_en_nxt = 1'b0;
    endcase
  end

  // Drivers off under reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      drv_en_out <= 1'b0;
    end else if (ce_in) begin
      drv_en_out <= drv_en_nxt;
    end
  end

endmodule

// ==== logic/dual_serial_board_control_port.sv ====
`timescale 1ns/1ps
// Behaviour
// - Eight-byte window; four serial, port at +4
// - Write bits 0,1 drive DTR A,B
// - Bits 2-5 drive local/remote loopback A,B
// - Bit 7 DMA enable A, bit 6 B
// - Read bits 0,1 give DSR, active low
// - Read bits 2,4 give test mode, inverted
// - Read bit 3 serial irq, active low
// - Read bit 5 terminal-count latch, active low
// - TC strap: terminal count on a DMA-enabled channel sets latch, irq
// - Write at +5 clears latch unless a count sets it
// - DMA strap: soft, always, never
// - Strap routes irq to one line or none
// - Strap selects normal or shared irq
// - Reset clears software DMA enables
// - Never-enabled channel keeps DMA drivers off
// - Decode compares only ten address lines
module dual_serial_board_control_port #(
  parameter int unsigned ADDR_W = board_ctl_pkg::DEC_ADDR_W
) (
  // Clock, reset, enable
  input  wire logic                     clk_in,
  input  wire logic                     srst_in,
  input  wire logic                     ce_in,
  // Host I/O bus
  input  wire logic [ADDR_W-1:0]        base_addr_in,
  input  wire logic [ADDR_W-1:0]        io_addr_in,
  input  wire logic                     io_rd_in,
  input  wire logic                     io_wr_in,
  input  wire logic [7:0]               io_wdata_in,
  output logic      [7:0]               io_rdata_out,
  output logic                          io_rdata_oe_out,
  // Serial controller access
  input  wire logic [7:0]               sc_rdata_in,
  output logic                          sc_sel_out,
  output logic      [1:0]               sc_reg_out,
  // Line status and serial controller irq
  input  wire board_ctl_pkg::line_stat_t line_stat_in,
  input  wire logic                     serial_controller_irq_status_in,
  // DMA terminal counts per channel
  input  wire logic                     tc_a_in,
  input  wire logic                     tc_b_in,
  // Straps
  input  wire board_ctl_pkg::dma_gate_t dma_gating_strap_a_in,
  input  wire board_ctl_pkg::dma_gate_t dma_gating_strap_b_in,
  input  wire board_ctl_pkg::irq_mode_t irq_mode_strap_in,
  input  wire logic [3:0]               irq_line_strap_in,
  // Modem/loopback outputs
  output board_ctl_pkg::modem_ctl_t     modem_ctl_out,
  // DMA driver enables
  output logic                          dma_drv_en_a_out,
  output logic                          dma_drv_en_b_out,
  // Host irq lines (drive value and enable)
  output logic [board_ctl_pkg::IRQ_LINES-1:0] irq_line_out,
  output logic [board_ctl_pkg::IRQ_LINES-1:0] irq_line_oe_out,
  output logic                          irq_share_pulldown_out
);

  // ==========================================================
  // Address decode
  // Window match on the upper address bits only
  function automatic logic in_window(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    in_window = (a[ADDR_W-1:3] == b[ADDR_W-1:3]);
  endfunction

  // Serial controller owns the half of the window with offset bit 2 clear
  localparam logic OFS_SERIAL_LO_BIT = board_ctl_pkg::OFS_SERIAL_LO[2];

  // Decode results, all combinational
  logic       hit;
  logic [2:0] ofs;
  logic       sc_hit;
  logic       port_rd;
  logic       port_wr;
  logic       tc_clr;

  // Only the low ten lines take part, so aliases above repeat
  always_comb begin
    hit     = in_window(io_addr_in, base_addr_in);
    ofs     = io_addr_in[2:0];
    sc_hit  = hit && (ofs[2] == OFS_SERIAL_LO_BIT);
    port_rd = hit && io_rd_in && (ofs == board_ctl_pkg::OFS_CTRL_STAT);
    port_wr = hit && io_wr_in && (ofs == board_ctl_pkg::OFS_CTRL_STAT);
    tc_clr  = hit && io_wr_in && (ofs == board_ctl_pkg::OFS_TC_CLEAR);
  end

  // ==========================================================
  // Control register and terminal-count latch
  // Control byte holds exactly what the host last wrote
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic       tc_latch_r;
  logic       tc_latch_nxt;
  logic       tc_event;

  // Terminal count only matters on channels actually doing DMA
  always_comb begin
    tc_event = (irq_mode_strap_in == board_ctl_pkg::IRQ_TC) &&
               ((tc_a_in && dma_drv_en_a_out) || (tc_b_in && dma_drv_en_b_out));
    // Whole byte is taken; fields split out on the way to the pins
    ctrl_nxt = port_wr ? io_wdata_in : ctrl_r;
    // Set wins so a count arriving with the clear is not lost
    if (tc_event) begin
      tc_latch_nxt = 1'b1;
    end else if (tc_clr) begin
      tc_latch_nxt = 1'b0;
    end else begin
      tc_latch_nxt = tc_latch_r;
    end
  end

  // Control byte and latch freeze together while enable is low
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_r     <= board_ctl_pkg::CTRL_RST;
      tc_latch_r <= 1'b0;
    end else if (ce_in) begin
      ctrl_r     <= ctrl_nxt;
      tc_latch_r <= tc_latch_nxt;
    end
  end

  // ==========================================================
  // Per-channel DMA gating
  // Channel A software enable comes from bit 7
  dma_gate u_gate_a (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .ce_in      (ce_in),
    .strap_in   (dma_gating_strap_a_in),
    .soft_en_in (ctrl_r[board_ctl_pkg::WR_DMA_A]),
    .drv_en_out (dma_drv_en_a_out)
  );

  // Channel B software enable comes from bit 6
  dma_gate u_gate_b (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .ce_in      (ce_in),
    .strap_in   (dma_gating_strap_b_in),
    .soft_en_in (ctrl_r[board_ctl_pkg::WR_DMA_B]),
    .drv_en_out (dma_drv_en_b_out)
  );

  // ==========================================================
  // Read data, outputs and interrupt routing
  // Next values for every registered pin
  logic [7:0]                        stat;
  logic [7:0]                        rdata_nxt;
  logic                              rdata_oe_nxt;
  logic                              sc_sel_nxt;
  board_ctl_pkg::modem_ctl_t         modem_nxt;
  logic                              board_irq;
  logic [board_ctl_pkg::IRQ_LINES-1:0] line_nxt;
  logic [board_ctl_pkg::IRQ_LINES-1:0] line_oe_nxt;
  logic                              pulldown_nxt;

  // Status byte: every flag reads zero when active
  always_comb begin
    stat                           = 8'h00;
    stat[board_ctl_pkg::RD_DSR_A]  = ~line_stat_in.dsr_a;
    stat[board_ctl_pkg::RD_DSR_B]  = ~line_stat_in.dsr_b;
    stat[board_ctl_pkg::RD_TM_A]   = ~line_stat_in.tm_a;
    stat[board_ctl_pkg::RD_SC_IRQ] = ~serial_controller_irq_status_in;
    stat[board_ctl_pkg::RD_TM_B]   = ~line_stat_in.tm_b;
    stat[board_ctl_pkg::RD_TC]     = ~tc_latch_r;
    stat[board_ctl_pkg::RD_DMA_B]  = ~dma_drv_en_b_out;
    stat[board_ctl_pkg::RD_DMA_A]  = ~dma_drv_en_a_out;
    // Offsets 5 to 7 return nothing, so the data bus stays free
    rdata_oe_nxt = hit && io_rd_in && (sc_hit || port_rd);
    rdata_nxt    = port_rd ? stat : (sc_hit ? sc_rdata_in : 8'h00);
    sc_sel_nxt   = sc_hit && (io_rd_in || io_wr_in);
    // Modem pins mirror the control byte one cycle later
    modem_nxt.dtr_a = ctrl_r[board_ctl_pkg::WR_DTR_A];
    modem_nxt.dtr_b = ctrl_r[board_ctl_pkg::WR_DTR_B];
    modem_nxt.ll_a  = ctrl_r[board_ctl_pkg::WR_LL_A];
    modem_nxt.rl_a  = ctrl_r[board_ctl_pkg::WR_RL_A];
    modem_nxt.ll_b  = ctrl_r[board_ctl_pkg::WR_LL_B];
    modem_nxt.rl_b  = ctrl_r[board_ctl_pkg::WR_RL_B];
  end

  // Shared mode drives only while asserting; normal mode drives always
  always_comb begin
    board_irq    = serial_controller_irq_status_in || tc_latch_r;
    line_nxt     = '0;
    line_oe_nxt  = '0;
    pulldown_nxt = (irq_mode_strap_in == board_ctl_pkg::IRQ_SHARED);
    // Strap values outside 1..9 leave every line undriven
    for (int i = 0; i < board_ctl_pkg::IRQ_LINES; i++) begin
      if (irq_line_strap_in == 4'(i + 1)) begin
        line_nxt[i]    = board_irq;
        line_oe_nxt[i] = pulldown_nxt ? board_irq : 1'b1;
      end
    end
  end

  // All outputs registered
  // One cycle of latency on every path buys glitch-free pins
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      io_rdata_out           <= 8'h00;
      io_rdata_oe_out        <= 1'b0;
      sc_sel_out             <= 1'b0;
      sc_reg_out             <= 2'h0;
      modem_ctl_out          <= '0;
      irq_line_out           <= '0;
      irq_line_oe_out        <= '0;
      irq_share_pulldown_out <= 1'b0;
    end else if (ce_in) begin
      io_rdata_out           <= rdata_nxt;
      io_rdata_oe_out        <= rdata_oe_nxt;
      sc_sel_out             <= sc_sel_nxt;
      sc_reg_out             <= ofs[1:0];
      modem_ctl_out          <= modem_nxt;
      irq_line_out           <= line_nxt;
      irq_line_oe_out        <= line_oe_nxt;
      irq_share_pulldown_out <= pulldown_nxt;
    end
  end

endmodule

// ==== sim/board_port_chk.sv ====
`timescale 1ns/1ps
// ==========================================
// Port checker on top-level pins
module board_port_chk #(parameter int unsigned ADDR_W = 10) (
  // Clock and host bus
  input wire logic                      clk_in, srst_in, ce_in, io_rd_in, io_wr_in,
  input wire logic [ADDR_W-1:0]         base_addr_in, io_addr_in,
  input wire logic [7:0]                io_wdata_in, io_rdata_out,
  input wire logic                      io_rdata_oe_out, sc_sel_out,
  input wire logic [1:0]                sc_reg_out,
  // Status and straps
  input wire board_ctl_pkg::line_stat_t line_stat_in,
  input wire board_ctl_pkg::dma_gate_t  dma_gating_strap_a_in, dma_gating_strap_b_in,
  input wire board_ctl_pkg::irq_mode_t  irq_mode_strap_in,
  input wire logic [3:0]                irq_line_strap_in,
  // Outputs
  input wire board_ctl_pkg::modem_ctl_t modem_ctl_out,
  input wire logic                      dma_drv_en_a_out, dma_drv_en_b_out, irq_share_pulldown_out,
  input wire logic [board_ctl_pkg::IRQ_LINES-1:0] irq_line_oe_out
);
  // Window hit; upper bits above ten lines do not exist
  wire hit = io_addr_in[ADDR_W-1:3] == base_addr_in[ADDR_W-1:3];
  wire wr4 = ce_in && io_wr_in && hit && io_addr_in[2:0] == 3'h4;
  wire rd4 = ce_in && io_rd_in && hit && io_addr_in[2:0] == 3'h4;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  a_rst_clear: assert property (disable iff (1'b0) srst_in && ce_in |=> modem_ctl_out == 6'h00
    && !dma_drv_en_a_out && !dma_drv_en_b_out) else $error("reset left outputs set");
  a_wr_modem: assert property (wr4 |-> ##2 modem_ctl_out == $past(io_wdata_in[5:0], 2))
    else $error("modem bits differ from write");
  a_soft_dma: assert property (wr4 && dma_gating_strap_a_in == board_ctl_pkg::DMA_SOFT
    |-> ##2 dma_drv_en_a_out == $past(io_wdata_in[7], 2)) else $error("soft dma enable wrong");
  a_never_off: assert property (dma_gating_strap_b_in[1] [*3] |-> !dma_drv_en_b_out)
    else $error("never channel driving");
  a_always_on: assert property ((ce_in && dma_gating_strap_a_in == board_ctl_pkg::DMA_ALWAYS) [*3]
    |-> dma_drv_en_a_out) else $error("always channel off");
  a_rd_drive: assert property (rd4 |=> io_rdata_oe_out) else $error("port read not driven");
  a_rd_dsr: assert property (rd4 && $stable(line_stat_in) |=> io_rdata_out[1:0] ==
    ~$past({line_stat_in.dsr_b, line_stat_in.dsr_a})) else $error("dsr bits wrong");
  a_serial_sel: assert property (ce_in && (io_rd_in || io_wr_in) && hit && !io_addr_in[2]
    |=> sc_sel_out && sc_reg_out == $past(io_addr_in[1:0])) else $error("serial select wrong");
  a_no_line: assert property ((irq_line_strap_in == 4'h0) [*2] |-> irq_line_oe_out == '0)
    else $error("line driven without strap");
  a_share_pd: assert property ((irq_mode_strap_in == board_ctl_pkg::IRQ_SHARED) [*2]
    |-> irq_share_pulldown_out) else $error("pulldown missing");
  c_wr: cover property (wr4);
  c_tc: cover property (io_rdata_oe_out && !io_rdata_out[5]);
  c_share: cover property (irq_share_pulldown_out && irq_line_oe_out != '0);
endmodule
bind dual_serial_board_control_port board_port_chk #(.ADDR_W(ADDR_W)) i_chk (.*);

// ==== sim/dma_host_model.sv ====
`timescale 1ns/1ps
// ==========================================
// DMA controller side: terminal count pulses
module dma_host_model (
  input  wire logic clk_in,
  input  wire logic go_a_in,
  input  wire logic go_b_in,
  output logic      tc_a_out,
  output logic      tc_b_out
);
  // Pulses whether or not the board has the channel enabled
  always_ff @(posedge clk_in) begin
    tc_a_out <= go_a_in;
    tc_b_out <= go_b_in;
  end
endmodule

// ==== sim/dual_serial_board_control_port_tb.sv ====
`timescale 1ns/1ps
module dual_serial_board_control_port_tb;
  // ==========================================
  // Pins and bench state
  localparam logic [9:0] BASE = 10'h300;
  logic clk_in = 1'b0, srst_in = 1'b1, ce_in = 1'b1, io_rd_in = 1'b0, io_wr_in = 1'b0, go_a = 1'b0, go_b = 1'b0;
  logic [9:0] base_addr_in = BASE, io_addr_in = 10'h000;
  logic [7:0] io_wdata_in = 8'h00, io_rdata_out, rv;
  logic [7:0] mv [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h3f, 8'h00};
  logic [1:0] sc_reg_out;
  logic [2:0] sv;
  logic io_rdata_oe_out, sc_sel_out, ov, serial_controller_irq_status_in = 1'b0, e;
  logic tc_a_in, tc_b_in, dma_drv_en_a_out, dma_drv_en_b_out, irq_share_pulldown_out;
  board_ctl_pkg::line_stat_t line_stat_in = 4'h0;
  board_ctl_pkg::dma_gate_t dma_gating_strap_a_in = board_ctl_pkg::DMA_SOFT;
  board_ctl_pkg::dma_gate_t dma_gating_strap_b_in = board_ctl_pkg::DMA_SOFT;
  board_ctl_pkg::irq_mode_t irq_mode_strap_in = board_ctl_pkg::IRQ_NORMAL;
  logic [3:0] irq_line_strap_in = 4'h0;
  board_ctl_pkg::modem_ctl_t modem_ctl_out;
  logic [8:0] irq_line_out, irq_line_oe_out, x;
  int errors = 0, samples_checked = 0, cyc = 0, k;
  dual_serial_board_control_port i_dut (.clk_in, .srst_in, .ce_in, .base_addr_in, .io_addr_in, .io_rd_in,
    .io_wr_in, .io_wdata_in, .io_rdata_out, .io_rdata_oe_out, .sc_rdata_in(8'ha5), .sc_sel_out, .sc_reg_out,
    .line_stat_in, .serial_controller_irq_status_in, .tc_a_in, .tc_b_in, .dma_gating_strap_a_in,
    .dma_gating_strap_b_in, .irq_mode_strap_in, .irq_line_strap_in, .modem_ctl_out, .dma_drv_en_a_out,
    .dma_drv_en_b_out, .irq_line_out, .irq_line_oe_out, .irq_share_pulldown_out);
  dma_host_model i_host (.clk_in, .go_a_in(go_a), .go_b_in(go_b), .tc_a_out(tc_a_in), .tc_b_out(tc_b_in));
  always #10 clk_in = ~clk_in;
  // Ceiling far above the few hundred cycles needed
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  // ==========================================
  // Tasks
  task automatic summarize();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Write for one edge; returns after DMA enables settle
  task automatic bw(input logic [9:0] a, input logic [7:0] d);
    io_addr_in = a;
    io_wdata_in = d;
    io_wr_in = 1'b1;
    @(posedge clk_in);
    #1 io_wr_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  // Read held two edges so registered data is in place
  task automatic br(input logic [9:0] a);
    io_addr_in = a;
    io_rd_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 rv = io_rdata_out;
    ov = io_rdata_oe_out;
    sv = {sc_sel_out, sc_reg_out};
    io_rd_in = 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic tcp(input logic b);
    go_a = ~b;
    go_b = b;
    @(posedge clk_in);
    #1 go_a = 1'b0;
    go_b = 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  // ==========================================
  // Sequence
  initial begin
    repeat (10) @(posedge clk_in);
    #1 srst_in = 1'b0;
    chk({modem_ctl_out, dma_drv_en_a_out, dma_drv_en_b_out}, 24'h0);
    foreach (mv[i]) begin
      bw(BASE + 10'h4, mv[i]);
      chk(modem_ctl_out, mv[i][5:0]);
    end
    // Places outside the port must leave it alone
    bw(BASE + 10'h6, 8'hff);
    bw(BASE + 10'h104, 8'hff);
    chk(modem_ctl_out, 24'h0);
    // Enable low freezes the port: the write is not taken
    ce_in = 1'b0;
    bw(BASE + 10'h4, 8'h3f);
    chk(modem_ctl_out, 24'h0);
    ce_in = 1'b1;
    br(BASE + 10'h5);
    chk({ov, sv[2]}, 2'b00);
    br(BASE + 10'h2);
    chk({ov, rv, sv}, {1'b1, 8'ha5, 3'b110});
    bw(BASE + 10'h4, 8'h81);
    chk({dma_drv_en_a_out, dma_drv_en_b_out}, 2'b10);
    // Reset in mid-run drops the enables and the control byte
    srst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 srst_in = 1'b0;
    chk({modem_ctl_out, dma_drv_en_a_out, dma_drv_en_b_out}, 24'h0);
    br(BASE + 10'h4);
    chk({rv[7:6], dma_drv_en_a_out, modem_ctl_out.dtr_a}, 4'b1100);
    for (k = 0; k < 6; k++) begin
      dma_gating_strap_a_in = board_ctl_pkg::dma_gate_t'(k / 2);
      dma_gating_strap_b_in = dma_gating_strap_a_in;
      e = (k / 2 == 1) || (k == 1);
      bw(BASE + 10'h4, {k[0], k[0], 6'h00});
      chk({dma_drv_en_a_out, dma_drv_en_b_out}, {e, e});
      br(BASE + 10'h4);
      chk(rv[7:6], {~e, ~e});
    end
    for (k = 0; k < 32; k++) begin
      line_stat_in = k[3:0];
      serial_controller_irq_status_in = k[4];
      br(BASE + 10'h4);
      chk(rv, {3'b111, ~k[3], ~k[4], ~k[2], ~k[1], ~k[0]});
    end
    // Count on a never channel is ignored; on an enabled one it latches
    irq_mode_strap_in = board_ctl_pkg::IRQ_TC;
    irq_line_strap_in = 4'h1;
    serial_controller_irq_status_in = 1'b0;
    tcp(1'b1);
    br(BASE + 10'h4);
    chk(rv[5], 1'b1);
    dma_gating_strap_a_in = board_ctl_pkg::DMA_ALWAYS;
    tcp(1'b0);
    br(BASE + 10'h4);
    chk({rv[5], irq_line_oe_out[0], irq_line_out[0]}, 3'b011);
    bw(BASE + 10'h5, 8'h5a);
    br(BASE + 10'h4);
    chk({rv[5], irq_line_out[0]}, 2'b10);
    irq_mode_strap_in = board_ctl_pkg::IRQ_NORMAL;
    serial_controller_irq_status_in = 1'b1;
    for (k = 0; k < 16; k++) begin
      irq_line_strap_in = k[3:0];
      x = (k >= 1 && k <= 9) ? 9'(1 << (k - 1)) : 9'h000;
      repeat (2) @(posedge clk_in);
      #1 chk({irq_share_pulldown_out, irq_line_oe_out, irq_line_oe_out & irq_line_out}, {1'b0, x, x});
    end
    // Shared line drives only while asserting
    irq_mode_strap_in = board_ctl_pkg::IRQ_SHARED;
    irq_line_strap_in = 4'h3;
    for (k = 0; k < 2; k++) begin
      serial_controller_irq_status_in = k[0];
      repeat (2) @(posedge clk_in);
      #1 chk({irq_share_pulldown_out, irq_line_oe_out}, {1'b1, 6'h00, k[0], 2'b00});
    end
    summarize();
  end
endmodule
